// file: hw/tcb_pkg.sv
// Constants and types shared by the channel 3 B/D capture-compare block
`default_nettype none
package tcb_pkg;
  // ********************************
  // Widths
  // ********************************
  localparam int unsigned TCB_GR_W   = 16;  // General register and counter width
  localparam int unsigned TCB_ADDR_W = 8;   // APB address width
  localparam int unsigned TCB_DATA_W = 32;  // APB data width

  // ********************************
  // Register byte addresses
  // ********************************
  localparam logic [7:0] TCB_OFF_CTRL_HIGH = 8'h00;  // ch3_io_control_high
  localparam logic [7:0] TCB_OFF_CTRL_LOW  = 8'h04;  // ch3_io_control_low
  localparam logic [7:0] TCB_OFF_GEN_B     = 8'h08;  // ch3_general_b
  localparam logic [7:0] TCB_OFF_GEN_D     = 8'h0c;  // ch3_general_d
  localparam logic [7:0] TCB_OFF_STATUS    = 8'h10;  // Event flags and pin levels

  // ********************************
  // Field layout
  // ********************************
  localparam int unsigned TCB_FLD_LSB   = 4;  // Role field sits in bits 7:4
  localparam int unsigned TCB_ROLE_BIT  = 3;  // Field bit: 0 compare, 1 capture
  localparam int unsigned TCB_LEVEL_BIT = 2;  // Field bit: initial level / ch4 source
  localparam int unsigned TCB_ACT_HI    = 1;  // Field bit: action high
  localparam int unsigned TCB_ACT_LO    = 0;  // Field bit: action low

  // Status bit positions
  localparam int unsigned TCB_ST_MATCH_B = 0;
  localparam int unsigned TCB_ST_CAPT_B  = 1;
  localparam int unsigned TCB_ST_MATCH_D = 2;
  localparam int unsigned TCB_ST_CAPT_D  = 3;
  localparam int unsigned TCB_ST_PIN_B   = 4;
  localparam int unsigned TCB_ST_PIN_D   = 5;

  // ********************************
  // Reset values and codes
  // ********************************
  localparam logic [7:0]          TCB_RST_CTRL    = 8'h00;
  localparam logic [TCB_GR_W-1:0] TCB_RST_GR      = 16'hffff;
  localparam logic [2:0]          TCB_PSC_UNDIV   = 3'h0;  // Undivided ch4 clock
  localparam logic [1:0]          TCB_ACT_NONE    = 2'h0;
  localparam logic [1:0]          TCB_ACT_CLR     = 2'h1;
  localparam logic [1:0]          TCB_ACT_SET     = 2'h2;
  localparam logic [1:0]          TCB_ACT_TOGGLE  = 2'h3;
  localparam logic [1:0]          TCB_EDGE_RISE   = 2'h0;
  localparam logic [1:0]          TCB_EDGE_FALL   = 2'h1;
endpackage : tcb_pkg
`default_nettype wire

// file: hw/tcb_top.sv
// Channel 3 B/D register I/O control with APB register access
//
// Operation
// - Role bit 0 means compare; 0000/0100 pin off
// - Level bit picks initial pin level
// - Action 01 drives pin low on match
// - Action 10 drives pin high on match
// - Action 11 toggles pin on match
// - Capture mode 1000 captures on rising edge
// - Capture mode 1001 captures on falling edge
// - Capture mode 101x (action-high set, level bit clear): both edges
// - Mode 11xx captures on ch4 count events
// - Undivided ch4 prescale gives no capture in mode 11xx
// - D buffer mode disables D compare, capture and pin drive; the D register stays writable
// - B field high reg, D field low
//
// Chosen here: the APB register port and the placing of the registers.
`default_nettype none
module tcb_top
  import tcb_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                  i_clk,
  input  wire logic                  i_reset,
  input  wire logic                  i_ce,
  // APB slave
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [TCB_ADDR_W-1:0] i_paddr,
  input  wire logic [TCB_DATA_W-1:0] i_pwdata,
  output logic      [TCB_DATA_W-1:0] o_prdata,
  output logic                       o_pready,
  output logic                       o_pslverr,
  // Timer context
  input  wire logic [TCB_GR_W-1:0]   i_ch3_count,
  input  wire logic                  i_ch4_count_up,
  input  wire logic                  i_ch4_count_down,
  input  wire logic [2:0]            i_ch4_prescale_sel,
  input  wire logic                  i_d_buffer_mode,
  // Pin B
  input  wire logic                  i_ch3_pin_b,
  output logic                       o_ch3_pin_b,
  output logic                       o_ch3_pin_b_oe_n,
  // Pin D
  input  wire logic                  i_ch3_pin_d,
  output logic                       o_ch3_pin_d,
  output logic                       o_ch3_pin_d_oe_n,
  // Event pulses
  output logic                       o_match_b,
  output logic                       o_capture_b,
  output logic                       o_match_d,
  output logic                       o_capture_d
);

  // ********************************
  // Declarations
  // ********************************
  tcb_unit_if unit_b ();                                // B register link
  tcb_unit_if unit_d ();                                // D register link

  logic [7:0]            ctrl_hi_r,  ctrl_hi_nxt;       // ch3_io_control_high
  logic [7:0]            ctrl_lo_r,  ctrl_lo_nxt;       // ch3_io_control_low
  logic [3:0]            flags_r,    flags_nxt;         // Sticky event flags
  logic [TCB_DATA_W-1:0] prdata_r,   prdata_nxt;        // Read data
  logic                  pready_r,   pready_nxt;        // Access-phase ready
  logic                  pslverr_r,  pslverr_nxt;       // Unmapped address

  logic                  setup;       // APB setup phase
  logic                  wr_fire;     // Write completes this edge
  logic                  hit_map;     // Address is mapped
  logic                  wr_hi;       // Write to high control
  logic                  wr_lo;       // Write to low control
  logic                  wr_status;   // Write to status
  logic                  ch4_ok;      // Ch4 events usable
  logic                  ch4_evt;     // Qualified ch4 event
  logic [3:0]            evt;         // New event pulses

  // ********************************
  // APB decode
  // ********************************
  always_comb begin
    setup     = i_psel && !i_penable;
    hit_map   = (i_paddr == TCB_OFF_CTRL_HIGH) || (i_paddr == TCB_OFF_CTRL_LOW) ||
                (i_paddr == TCB_OFF_GEN_B) || (i_paddr == TCB_OFF_GEN_D) ||
                (i_paddr == TCB_OFF_STATUS);
    // Writes land only at the edge that completes the access
    wr_fire   = i_psel && i_penable && pready_r && i_pwrite && hit_map;
    wr_hi     = wr_fire && (i_paddr == TCB_OFF_CTRL_HIGH);
    wr_lo     = wr_fire && (i_paddr == TCB_OFF_CTRL_LOW);
    wr_status = wr_fire && (i_paddr == TCB_OFF_STATUS);
  end

  // ********************************
  // Channel 4 event qualification
  // ********************************
  always_comb begin
    // Undivided ch4 clock makes the ch4 capture source invalid
    ch4_ok  = (i_ch4_prescale_sel != TCB_PSC_UNDIV);
    ch4_evt = ch4_ok && (i_ch4_count_up || i_ch4_count_down);
  end

  // ********************************
  // Unit hookup
  // ********************************
  always_comb begin
    unit_b.field    = ctrl_hi_r[TCB_FLD_LSB +: 4];
    unit_b.cfg_load = wr_hi && i_ce;
    unit_b.blocked  = 1'b0;
    unit_b.count    = i_ch3_count;
    unit_b.ch4_evt  = ch4_evt;
    unit_b.wr_en    = wr_fire && (i_paddr == TCB_OFF_GEN_B);
    unit_b.wr_data  = i_pwdata[TCB_GR_W-1:0];
    unit_b.pin_in   = i_ch3_pin_b;
    unit_d.field    = ctrl_lo_r[TCB_FLD_LSB +: 4];
    unit_d.cfg_load = wr_lo && i_ce;
    unit_d.blocked  = i_d_buffer_mode;
    unit_d.count    = i_ch3_count;
    unit_d.ch4_evt  = ch4_evt;
    unit_d.wr_en    = wr_fire && (i_paddr == TCB_OFF_GEN_D);
    unit_d.wr_data  = i_pwdata[TCB_GR_W-1:0];
    unit_d.pin_in   = i_ch3_pin_d;
  end

  // The field takes effect one edge after the write, so the
  // initial level is loaded from the new field on the next cycle
  tcb_unit u_unit_b (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_ce    (i_ce),
    .u       (unit_b.unit)
  );

  tcb_unit u_unit_d (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_ce    (i_ce),
    .u       (unit_d.unit)
  );

  // ********************************
  // Register file next state
  // ********************************
  always_comb begin
    ctrl_hi_nxt = ctrl_hi_r;
    ctrl_lo_nxt = ctrl_lo_r;
    if (wr_hi) begin
      ctrl_hi_nxt = i_pwdata[7:0];
    end
    if (wr_lo) begin
      ctrl_lo_nxt = i_pwdata[7:0];
    end
    evt = {unit_d.capture, unit_d.match, unit_b.capture, unit_b.match};
    // Write one to clear; a new event in the same cycle wins
    flags_nxt = flags_r;
    if (wr_status) begin
      flags_nxt = flags_r & ~i_pwdata[3:0];
    end
    flags_nxt = flags_nxt | evt;
  end

  // ********************************
  // APB answer next state
  // ********************************
  always_comb begin
    // Ready rises in the first access cycle: one wait-free transfer
    pready_nxt  = setup;
    pslverr_nxt = setup && !hit_map;
    prdata_nxt  = prdata_r;
    if (setup) begin
      prdata_nxt = '0;
      if (!i_pwrite) begin
        case (i_paddr)
          TCB_OFF_CTRL_HIGH: prdata_nxt[7:0]          = ctrl_hi_r;
          TCB_OFF_CTRL_LOW:  prdata_nxt[7:0]          = ctrl_lo_r;
          TCB_OFF_GEN_B:     prdata_nxt[TCB_GR_W-1:0] = unit_b.gr;
          TCB_OFF_GEN_D:     prdata_nxt[TCB_GR_W-1:0] = unit_d.gr;
          TCB_OFF_STATUS: begin
            prdata_nxt[3:0]            = flags_r;
            prdata_nxt[TCB_ST_PIN_B]   = unit_b.pin_out;
            prdata_nxt[TCB_ST_PIN_D]   = unit_d.pin_out;
          end
          default:           prdata_nxt = '0;
        endcase
      end
    end
  end

  // ********************************
  // Registers
  // ********************************
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctrl_hi_r <= TCB_RST_CTRL;
      ctrl_lo_r <= TCB_RST_CTRL;
      flags_r   <= 4'h0;
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (i_ce) begin
      ctrl_hi_r <= ctrl_hi_nxt;
      ctrl_lo_r <= ctrl_lo_nxt;
      flags_r   <= flags_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ********************************
  // Outputs, all from flops
  // ********************************
  assign o_prdata         = prdata_r;
  assign o_pready         = pready_r;
  assign o_pslverr        = pslverr_r;
  assign o_ch3_pin_b      = unit_b.pin_out;
  assign o_ch3_pin_b_oe_n = unit_b.pin_oe_n;
  assign o_ch3_pin_d      = unit_d.pin_out;
  assign o_ch3_pin_d_oe_n = unit_d.pin_oe_n;
  assign o_match_b        = unit_b.match;
  assign o_capture_b      = unit_b.capture;
  assign o_match_d        = unit_d.match;
  assign o_capture_d      = unit_d.capture;

endmodule : tcb_top
`default_nettype wire

// file: hw/tcb_unit.sv
// One general register with its pin: output compare or input capture
`default_nettype none
module tcb_unit
  import tcb_pkg::*;
(
  // Clock and control
  input  wire logic    i_clk,
  input  wire logic    i_reset,
  input  wire logic    i_ce,
  // Link to top
  tcb_unit_if.unit     u
);

  // ********************************
  // State
  // ********************************
  logic [TCB_GR_W-1:0] gr_r,       gr_nxt;        // General register
  logic                pin_r,      pin_nxt;       // Driven pin level
  logic                oe_n_r,     oe_n_nxt;      // Pin enable, low drives
  logic                pin_prev_r, pin_prev_nxt;  // Last pin sample
  logic                eq_prev_r,  eq_prev_nxt;   // Last equality
  logic                match_r,    match_nxt;     // Match pulse
  logic                capt_r,     capt_nxt;      // Capture pulse
  logic                load_r,     load_nxt;      // Field written at last edge

  logic                is_cmp;    // Compare role active
  logic                is_cap;    // Capture role active
  logic                equal;     // Counter equals register
  logic                hit;       // Match edge this cycle
  logic                cap_evt;   // Capture trigger this cycle
  logic [1:0]          act;       // Low two field bits

  // ********************************
  // Next-state logic
  // ********************************
  always_comb begin
    act          = u.field[TCB_ACT_HI:TCB_ACT_LO];
    is_cmp       = !u.field[TCB_ROLE_BIT] && !u.blocked;
    is_cap       = u.field[TCB_ROLE_BIT] && !u.blocked;
    equal        = (u.count == gr_r);
    // Only the first cycle of equality counts, so a stalled counter gives one match
    hit          = is_cmp && equal && !eq_prev_r;
    cap_evt      = 1'b0;
    if (is_cap) begin
      if (u.field[TCB_LEVEL_BIT]) begin
        cap_evt = u.ch4_evt;
      end else if (u.field[TCB_ACT_HI]) begin
        cap_evt = (u.pin_in != pin_prev_r);
      end else if (act == TCB_EDGE_RISE) begin
        cap_evt = u.pin_in && !pin_prev_r;
      end else begin
        cap_evt = !u.pin_in && pin_prev_r;
      end
    end
    gr_nxt       = gr_r;
    // Capture beats a software write in the same cycle
    if (cap_evt) begin
      gr_nxt = u.count;
    end else if (u.wr_en) begin
      gr_nxt = u.wr_data;
    end
    pin_nxt      = pin_r;
    // Wait one edge so the level comes from the new field, not the old one
    if (load_r && is_cmp && (act != TCB_ACT_NONE)) begin
      pin_nxt = u.field[TCB_LEVEL_BIT];
    end else if (hit) begin
      case (act)
        TCB_ACT_CLR:    pin_nxt = 1'b0;
        TCB_ACT_SET:    pin_nxt = 1'b1;
        TCB_ACT_TOGGLE: pin_nxt = !pin_r;
        default:        pin_nxt = pin_r;
      endcase
    end
    oe_n_nxt     = !(is_cmp && (act != TCB_ACT_NONE));
    pin_prev_nxt = u.pin_in;
    eq_prev_nxt  = equal;
    match_nxt    = hit;
    capt_nxt     = cap_evt;
    load_nxt     = u.cfg_load;
  end

  // ********************************
  // Registers
  // ********************************
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      gr_r       <= TCB_RST_GR;
      pin_r      <= 1'b0;
      oe_n_r     <= 1'b1;
      pin_prev_r <= 1'b0;
      eq_prev_r  <= 1'b0;
      match_r    <= 1'b0;
      capt_r     <= 1'b0;
      load_r     <= 1'b0;
    end else if (i_ce) begin
      gr_r       <= gr_nxt;
      pin_r      <= pin_nxt;
      oe_n_r     <= oe_n_nxt;
      pin_prev_r <= pin_prev_nxt;
      eq_prev_r  <= eq_prev_nxt;
      match_r    <= match_nxt;
      capt_r     <= capt_nxt;
      load_r     <= load_nxt;
    end
  end

  assign u.gr       = gr_r;
  assign u.pin_out  = pin_r;
  assign u.pin_oe_n = oe_n_r;
  assign u.match    = match_r;
  assign u.capture  = capt_r;

endmodule : tcb_unit
`default_nettype wire

// file: hw/tcb_unit_if.sv
// Bundle between the top block and one general register unit
`default_nettype none
interface tcb_unit_if;
  import tcb_pkg::*;
  logic [3:0]          field;     // Role field of this register
  logic                cfg_load;  // Field written this cycle
  logic                blocked;   // Setting invalid, unit idle
  logic [TCB_GR_W-1:0] count;     // Channel 3 counter value
  logic                ch4_evt;   // Qualified channel 4 count event
  logic                wr_en;     // Software write of general register
  logic [TCB_GR_W-1:0] wr_data;   // Write value
  logic [TCB_GR_W-1:0] gr;        // General register content
  logic                pin_in;    // Pin level seen
  logic                pin_out;   // Pin level driven
  logic                pin_oe_n;  // Low while pin driven
  logic                match;     // One-cycle compare match
  logic                capture;   // One-cycle capture event

  modport top  (output field, cfg_load, blocked, count, ch4_evt, wr_en, wr_data, pin_in,
                input gr, pin_out, pin_oe_n, match, capture);
  modport unit (input field, cfg_load, blocked, count, ch4_evt, wr_en, wr_data, pin_in,
                output gr, pin_out, pin_oe_n, match, capture);
endinterface : tcb_unit_if
`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the channel 3 B/D capture-compare block
`default_nettype none
module tb
  import tcb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Signals
  // ****************
  logic                  clk, rst, psel, pen, pwr, up, dn, bufm, ext_b, ext_d, serr;
  logic [TCB_ADDR_W-1:0] addr;
  logic [TCB_DATA_W-1:0] wdata, rdata, prdata;
  logic [TCB_GR_W-1:0]   cnt;
  logic [2:0]            psc;
  logic                  pready, pslverr, pin_b, oe_b, pin_d, oe_d, wire_b, wire_d;
  int                    n_errors = 0;
  int                    cmp_count = 0;
  // Design and the two pins
  tcb_top uut (.i_clk(clk), .i_reset(rst), .i_ce(1'b1), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(addr), .i_pwdata(wdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_ch3_count(cnt), .i_ch4_count_up(up), .i_ch4_count_down(dn), .i_ch4_prescale_sel(psc),
    .i_d_buffer_mode(bufm), .i_ch3_pin_b(wire_b), .o_ch3_pin_b(pin_b), .o_ch3_pin_b_oe_n(oe_b),
    .i_ch3_pin_d(wire_d), .o_ch3_pin_d(pin_d), .o_ch3_pin_d_oe_n(oe_d),
    .o_match_b(), .o_capture_b(), .o_match_d(), .o_capture_d());
  tcb_pin_model pm_b (.i_pin_out(pin_b), .i_pin_oe_n(oe_b), .i_ext(ext_b), .o_wire(wire_b));
  tcb_pin_model pm_d (.i_pin_out(pin_d), .i_pin_oe_n(oe_d), .i_ext(ext_d), .o_wire(wire_d));
  // ****************
  // Shared tasks
  // ****************
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // One APB transfer; a missing pready ends the run
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_errors++;
      finish_test();
    end
    rdata = prdata;
    serr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  // ****************
  // Scenarios
  // ****************
  // Reset values, readback and an unmapped place
  task automatic t_regs();
    apb(1'b0, TCB_OFF_CTRL_HIGH, 32'h0);
    chk("ctrl_high", rdata, 32'h0);
    apb(1'b0, TCB_OFF_GEN_D, 32'h0);
    chk("gen_d", rdata, 32'h0000ffff);
    apb(1'b1, TCB_OFF_CTRL_LOW, 32'h5a);
    apb(1'b0, TCB_OFF_CTRL_LOW, 32'h0);
    chk("ctrl_low", rdata, 32'h5a);
    apb(1'b1, TCB_OFF_CTRL_LOW, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'(serr), 32'h1);
  endtask
  // Every compare code of field B, match on equal count
  task automatic t_cmp();
    logic [1:0] act;
    logic       lvl, e;
    for (int c = 0; c < 8; c++) begin
      act = c[1:0];
      lvl = c[2];
      e = (act == TCB_ACT_CLR) ? 1'b0 : (act == TCB_ACT_SET) ? 1'b1 : !lvl;
      cnt <= 16'h0;
      apb(1'b1, TCB_OFF_CTRL_HIGH, {24'h0, c[3:0], 4'h0});
      apb(1'b1, TCB_OFF_GEN_B, 32'h0123);
      chk("oe_b", 32'(oe_b), 32'(act == TCB_ACT_NONE));
      if (act != TCB_ACT_NONE) chk("init_b", 32'(pin_b), 32'(lvl));
      cnt <= 16'h0123;
      repeat (3) @(posedge clk);
      if (act != TCB_ACT_NONE) chk("act_b", 32'(pin_b), 32'(e));
      apb(1'b0, TCB_OFF_STATUS, 32'h0);
      chk("flag_b", 32'(rdata[TCB_ST_MATCH_B]), 32'h1);
      apb(1'b1, TCB_OFF_STATUS, 32'h1);
    end
  endtask
  // Pin edge capture on B; previous level, new level, count, expected register
  task automatic t_cap(logic [3:0] f, logic p0, logic p1, logic [15:0] v, logic [15:0] e);
    ext_b <= p0;
    apb(1'b1, TCB_OFF_CTRL_HIGH, {24'h0, f, 4'h0});
    cnt <= v;
    ext_b <= p1;
    repeat (2) @(posedge clk);
    apb(1'b0, TCB_OFF_GEN_B, 32'h0);
    chk("capt_b", rdata, {16'h0, e});
  endtask
  // Capture on ch4 count pulses, one prescaler setting
  task automatic t_ch4(logic [2:0] ps, logic u, logic [15:0] v, logic [15:0] e);
    psc <= ps;
    apb(1'b1, TCB_OFF_CTRL_HIGH, 32'hc0);
    cnt <= v;
    up <= u;
    dn <= !u;
    @(posedge clk);
    up <= 1'b0;
    dn <= 1'b0;
    @(posedge clk);
    apb(1'b0, TCB_OFF_GEN_B, 32'h0);
    chk("ch4_b", rdata, {16'h0, e});
  endtask
  // D in buffer mode stays idle, then toggles once released
  task automatic t_dbuf();
    bufm <= 1'b1;
    apb(1'b1, TCB_OFF_CTRL_LOW, 32'h30);
    cnt <= 16'hffff;
    repeat (3) @(posedge clk);
    chk("oe_d_buf", 32'(oe_d), 32'h1);
    apb(1'b0, TCB_OFF_STATUS, 32'h0);
    chk("flag_d_buf", 32'(rdata[TCB_ST_MATCH_D]), 32'h0);
    bufm <= 1'b0;
    cnt <= 16'h0;
    // Rewrite the field once released so the initial level 0 is applied
    apb(1'b1, TCB_OFF_CTRL_LOW, 32'h30);
    apb(1'b1, TCB_OFF_GEN_D, 32'h0abc);
    cnt <= 16'h0abc;
    repeat (3) @(posedge clk);
    chk("oe_d", 32'(oe_d), 32'h0);
    chk("pin_d", 32'(pin_d), 32'h1);
    chk("oe_b_kept", 32'(oe_b), 32'h1);
  endtask
  // ****************
  // Clock and main sequence
  // ****************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    {psel, pen, pwr, up, dn, bufm, ext_b, ext_d} = 8'h0;
    addr = '0;
    wdata = '0;
    cnt = '0;
    psc = 3'h1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_cmp();
    t_cap(4'h8, 1'b0, 1'b1, 16'h1111, 16'h1111);
    t_cap(4'h9, 1'b1, 1'b0, 16'h2222, 16'h2222);
    t_cap(4'ha, 1'b0, 1'b1, 16'h3333, 16'h3333);
    t_cap(4'hb, 1'b1, 1'b0, 16'h4444, 16'h4444);
    t_cap(4'h8, 1'b1, 1'b0, 16'h5555, 16'h4444);
    t_ch4(3'h1, 1'b1, 16'h6666, 16'h6666);
    t_ch4(3'h2, 1'b0, 16'h7777, 16'h7777);
    t_ch4(3'h0, 1'b1, 16'h8888, 16'h7777);
    t_dbuf();
    finish_test();
  end
endmodule : tb
`default_nettype wire

// file: test/tcb_monitor.sv
// Port checker for the channel 3 B/D capture-compare block
`default_nettype none
module tcb_monitor
  import tcb_pkg::*;
(
  // Clock and reset
  input wire logic                  i_clk,
  input wire logic                  i_reset,
  input wire logic                  i_ce,
  // APB request and answer
  input wire logic                  i_psel,
  input wire logic                  i_penable,
  input wire logic                  i_pwrite,
  input wire logic [TCB_ADDR_W-1:0] i_paddr,
  input wire logic [TCB_DATA_W-1:0] i_pwdata,
  input wire logic                  o_pready,
  // Timer context
  input wire logic [TCB_GR_W-1:0]   i_ch3_count,
  input wire logic                  i_ch4_count_up,
  input wire logic                  i_ch4_count_down,
  input wire logic [2:0]            i_ch4_prescale_sel,
  input wire logic                  i_d_buffer_mode,
  // Pins and events
  input wire logic                  i_ch3_pin_b,
  input wire logic                  o_ch3_pin_b,
  input wire logic                  o_ch3_pin_b_oe_n,
  input wire logic                  o_ch3_pin_d_oe_n,
  input wire logic                  o_match_b,
  input wire logic                  o_capture_b,
  input wire logic                  o_match_d,
  input wire logic                  o_capture_d
);
  // ****************
  // Shadow of B state written over APB
  // ****************
  logic                wr_ok;         // Write takes effect this edge
  logic [3:0]          fb_r, fb_nxt;  // B role field
  logic [TCB_GR_W-1:0] gb_r, gb_nxt;  // B register, writes only: valid in compare role
  assign wr_ok = i_ce && i_psel && i_penable && i_pwrite && o_pready;
  // Next shadow values
  always_comb begin
    fb_nxt = fb_r;
    gb_nxt = gb_r;
    if (wr_ok && i_paddr == TCB_OFF_CTRL_HIGH) begin
      fb_nxt = i_pwdata[7:4];
    end
    if (wr_ok && i_paddr == TCB_OFF_GEN_B) begin
      gb_nxt = i_pwdata[TCB_GR_W-1:0];
    end
  end
  // Shadow registers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      fb_r <= TCB_RST_CTRL[7:4];
      gb_r <= TCB_RST_GR;
    end else begin
      fb_r <= fb_nxt;
      gb_r <= gb_nxt;
    end
  end
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  AST_OFF_B: assert property (!fb_r[3] && fb_r[1:0] == TCB_ACT_NONE |=> o_ch3_pin_b_oe_n)
    else $error("pin b driven while output disabled");
  AST_INIT_B: assert property (wr_ok && i_paddr == TCB_OFF_CTRL_HIGH && !i_pwdata[7] && i_pwdata[5:4] != 2'h0
    |-> ##2 o_ch3_pin_b == fb_r[2]) else $error("pin b initial level wrong");
  AST_CLR_B: assert property (o_match_b && !fb_r[3] && fb_r[1:0] == TCB_ACT_CLR |-> !o_ch3_pin_b)
    else $error("pin b not low after match");
  AST_SET_B: assert property (o_match_b && !fb_r[3] && fb_r[1:0] == TCB_ACT_SET |-> o_ch3_pin_b)
    else $error("pin b not high after match");
  AST_TGL_B: assert property (o_match_b && !fb_r[3] && fb_r[1:0] == TCB_ACT_TOGGLE
    |-> o_ch3_pin_b != $past(o_ch3_pin_b)) else $error("pin b not toggled on match");
  AST_MATCH_B: assert property (o_match_b && !fb_r[3] |-> $past(i_ch3_count) == gb_r)
    else $error("match b without equal count");
  AST_RISE_B: assert property (fb_r == 4'h8 && $rose(i_ch3_pin_b) |=> o_capture_b)
    else $error("rising edge not captured");
  AST_FALL_B: assert property (fb_r == 4'h9 && $fell(i_ch3_pin_b) |=> o_capture_b)
    else $error("falling edge not captured");
  AST_BOTH_B: assert property (fb_r[3:1] == 3'h5 && $changed(i_ch3_pin_b) |=> o_capture_b)
    else $error("edge not captured in both-edge mode");
  AST_CH4_B: assert property (fb_r[3:2] == 2'h3 && i_ch4_prescale_sel != TCB_PSC_UNDIV
    && (i_ch4_count_up || i_ch4_count_down) |=> o_capture_b) else $error("ch4 count not captured");
  AST_PSC_B: assert property (fb_r[3:2] == 2'h3 && i_ch4_prescale_sel == TCB_PSC_UNDIV |=> !o_capture_b)
    else $error("capture with undivided ch4 clock");
  AST_DBUF: assert property (i_d_buffer_mode [*2] |-> o_ch3_pin_d_oe_n && !o_capture_d && !o_match_d)
    else $error("d active in buffer mode");
endmodule : tcb_monitor
bind tcb_top tcb_monitor mon (.*);
`default_nettype wire

// file: test/tcb_pin_model.sv
// Outside circuit on one channel 3 pin
`default_nettype none
module tcb_pin_model (
  // Design side of the pin
  input  wire logic i_pin_out,
  input  wire logic i_pin_oe_n,
  // Level the outside circuit applies when the pin is released
  input  wire logic i_ext,
  // Level on the wire
  output logic      o_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  // Design wins while it drives, so captures only see the outside level
  assign o_wire = i_pin_oe_n ? i_ext : i_pin_out;
endmodule : tcb_pin_model
`default_nettype wire
